// ---- rtl/tim_mask_mode.sv ----
// Purpose: Second interrupt mask register upper half and mode control.
// Assumes: Register port is a simple byte write/read strobe interface.
// Notes:   Status bits are set by hardware, cleared by a read; set wins.
// Function
// - Mask bits 3, 4, 5 keep fan two, intrusion, overtemp status off the interrupt.
// - Mode bit 6 zero: hot event interrupts whenever temperature exceeds hot limit.
// - Mode bit 6 one: hot event interrupts once on rising past hot limit.
// - Mode bit 7 zero: overtemp event interrupts whenever temperature exceeds its limit.
// - Mode bit 7 one: overtemp event interrupts once on rising past its limit.
// - Default mode: read clears; each conversion sets again until below hysteresis.
// - One-time mode: next interrupt only on dropping below hysteresis, then none until the limit is exceeded again.
// - One-time mode: each read clears the bit; next conversion need not set it.
// - Intrusion status bit reads one once the intrusion input was high.
`timescale 1ns/1ps
`default_nettype none
module tim_mask_mode (
    input  wire logic       clk,                     // 125 MHz system clock.
    input  wire logic       rst,                     // Synchronous reset, active high.
    input  wire logic       reg_wr,                  // Register write strobe.
    input  wire logic       reg_rd,                  // Register read strobe.
    input  wire logic [7:0] reg_addr,                // Register address.
    input  wire logic [7:0] reg_wdata,               // Register write data.
    output logic      [7:0] reg_rdata,               // Registered read data.
    input  wire logic       conv_done,               // Conversion complete pulse.
    input  wire logic       hot_over,                // Above hot limit.
    input  wire logic       hot_below_hyst,          // Below hot hysteresis.
    input  wire logic       otl_over,                // Above overtemp limit.
    input  wire logic       otl_below_hyst,          // Below overtemp hysteresis.
    input  wire logic       second_fan_input,        // Second fan limit event, pin.
    input  wire logic       chassis_intrusion_input, // Intrusion pin.
    input  wire logic [2:0] low_status_set,          // Lower status bits 0..2 set requests.
    output logic            int_out,                 // Interrupt output, active high.
    output logic      [7:0] status_out,              // Status register mirror.
    output logic      [7:0] mask_out                 // Mask register mirror.
);
    // ==========================================================
    // Pin synchronisers: two flops before any logic looks at a pin.
    logic [1:0] fan_sync_reg;
    logic [1:0] intr_sync_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            fan_sync_reg  <= 2'h0;
            intr_sync_reg <= 2'h0;
        end else begin
            fan_sync_reg  <= {fan_sync_reg[0], second_fan_input};
            intr_sync_reg <= {intr_sync_reg[0], chassis_intrusion_input};
        end
    end

    // ==========================================================
    // Mask register with the two mode bits in its top half.
    logic [7:0] mask_reg;
    always_ff @(posedge clk) begin
        if (rst)
            mask_reg <= tim_pkg::MASK2_RESET;
        else if (reg_wr && reg_addr == tim_pkg::ADDR_MASK2)
            mask_reg <= reg_wdata;
    end

    // ==========================================================
    // Event trackers for the two temperature sources.
    logic hot_set;
    logic otl_set;
    tim_temp_event u_hot (
        .clk        (clk),
        .rst        (rst),
        .one_time   (mask_reg[tim_pkg::BIT_HOTMD]),
        .conv_done  (conv_done),
        .over_limit (hot_over),
        .below_hyst (hot_below_hyst),
        .set_pulse  (hot_set)
    );
    tim_temp_event u_otl (
        .clk        (clk),
        .rst        (rst),
        .one_time   (mask_reg[tim_pkg::BIT_OSMD]),
        .conv_done  (conv_done),
        .over_limit (otl_over),
        .below_hyst (otl_below_hyst),
        .set_pulse  (otl_set)
    );

    // ==========================================================
    // Status register: a read clears, but a set in the same cycle wins
    // so that no event slips between the read and the clear.
    logic [7:0] stat_reg;
    logic [7:0] stat_set;
    logic       stat_rd;
    always_comb begin
        stat_set = 8'h00;
        stat_set[2:0]               = low_status_set;
        stat_set[tim_pkg::BIT_HOT]  = low_status_set[0] | hot_set;
        stat_set[tim_pkg::BIT_FAN_TWO] = fan_sync_reg[1];
        stat_set[tim_pkg::BIT_CHASS] = intr_sync_reg[1];
        stat_set[tim_pkg::BIT_OSLIM] = otl_set;
    end
    assign stat_rd = reg_rd && reg_addr == tim_pkg::ADDR_STATUS2;
    always_ff @(posedge clk) begin
        if (rst)
            stat_reg <= tim_pkg::STAT2_RESET;
        else if (stat_rd)
            stat_reg <= stat_set & ~tim_pkg::STAT2_RSVD;
        else
            stat_reg <= (stat_reg | stat_set) & ~tim_pkg::STAT2_RSVD;
    end

    // ==========================================================
    // Interrupt output from unmasked status; mode bits never gate it.
    always_ff @(posedge clk) begin
        if (rst)
            int_out <= 1'b0;
        else
            int_out <= |(stat_reg & ~mask_reg & ~tim_pkg::STAT2_RSVD);
    end

    // ==========================================================
    // Read data and mirrors, registered so every output is a flop.
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata  <= 8'h00;
            status_out <= 8'h00;
            mask_out   <= 8'h00;
        end else begin
            status_out <= stat_reg;
            mask_out   <= mask_reg;
            if (reg_rd && reg_addr == tim_pkg::ADDR_STATUS2)
                reg_rdata <= stat_reg;
            else if (reg_rd && reg_addr == tim_pkg::ADDR_MASK2)
                reg_rdata <= mask_reg;
            else if (reg_rd)
                reg_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // Checks beside the logic.
    // A masked source on its own must leave the interrupt low.
    property p_mask_fan_two;
        @(posedge clk) disable iff (rst)
        (stat_reg[tim_pkg::BIT_FAN_TWO] && mask_reg[tim_pkg::BIT_FAN_TWO]
         && (stat_reg & ~mask_reg & ~tim_pkg::STAT2_RSVD) == 8'h00) |=> !int_out;
    endproperty
    a_mask_fan_two: assert property (p_mask_fan_two)
        else $error("Masked fan two raised interrupt.");
    property p_mask_intrusion;
        @(posedge clk) disable iff (rst)
        (stat_reg[tim_pkg::BIT_CHASS] && mask_reg[tim_pkg::BIT_CHASS]
         && (stat_reg & ~mask_reg & ~tim_pkg::STAT2_RSVD) == 8'h00) |=> !int_out;
    endproperty
    a_mask_intrusion: assert property (p_mask_intrusion)
        else $error("Masked intrusion raised interrupt.");
    // The interrupt follows the unmasked status one edge later, both ways.
    property p_int_on;
        @(posedge clk) disable iff (rst)
        ((stat_reg & ~mask_reg & ~tim_pkg::STAT2_RSVD) != 8'h00) |=> int_out;
    endproperty
    a_int_on: assert property (p_int_on)
        else $error("Interrupt missing for unmasked status.");
    property p_int_off;
        @(posedge clk) disable iff (rst)
        ((stat_reg & ~mask_reg) == 8'h00) |=> !int_out;
    endproperty
    a_int_off: assert property (p_int_off)
        else $error("Interrupt high with no unmasked status.");
    // Default mode sets the bit at every conversion that finds the limit exceeded.
    property p_hot_default;
        @(posedge clk) disable iff (rst)
        (conv_done && hot_over && !mask_reg[tim_pkg::BIT_HOTMD]) |=> stat_reg[tim_pkg::BIT_HOT];
    endproperty
    a_hot_default: assert property (p_hot_default)
        else $error("Hot default not set.");
    property p_otl_default;
        @(posedge clk) disable iff (rst)
        (conv_done && otl_over && !mask_reg[tim_pkg::BIT_OSMD]) |=> stat_reg[tim_pkg::BIT_OSLIM];
    endproperty
    a_otl_default: assert property (p_otl_default)
        else $error("Overtemp default not set.");
    // One-time mode stays quiet while the alarm is already latched and the limit is still exceeded.
    property p_hot_once;
        @(posedge clk) disable iff (rst)
        (conv_done && hot_over && mask_reg[tim_pkg::BIT_HOTMD] && u_hot.alarm_reg)
        |-> !hot_set;
    endproperty
    a_hot_once: assert property (p_hot_once)
        else $error("One-time hot repeated.");
    property p_otl_once;
        @(posedge clk) disable iff (rst)
        (conv_done && otl_over && mask_reg[tim_pkg::BIT_OSMD] && u_otl.alarm_reg)
        |-> !otl_set;
    endproperty
    a_otl_once: assert property (p_otl_once)
        else $error("One-time overtemp repeated.");
    // One-time mode raises once more when a latched alarm drops below hysteresis.
    property p_hot_rearm;
        @(posedge clk) disable iff (rst)
        (conv_done && mask_reg[tim_pkg::BIT_HOTMD] && u_hot.alarm_reg
         && !hot_over && hot_below_hyst) |=> stat_reg[tim_pkg::BIT_HOT];
    endproperty
    a_hot_rearm: assert property (p_hot_rearm)
        else $error("Hot drop below hysteresis not raised.");
    property p_otl_rearm;
        @(posedge clk) disable iff (rst)
        (conv_done && mask_reg[tim_pkg::BIT_OSMD] && u_otl.alarm_reg
         && !otl_over && otl_below_hyst) |=> stat_reg[tim_pkg::BIT_OSLIM];
    endproperty
    a_otl_rearm: assert property (p_otl_rearm)
        else $error("Overtemp drop below hysteresis not raised.");
    // A read clears a bit unless a set arrives in the same cycle.
    property p_rd_clear;
        @(posedge clk) disable iff (rst)
        (stat_rd && !stat_set[tim_pkg::BIT_OSLIM]) |=> !stat_reg[tim_pkg::BIT_OSLIM];
    endproperty
    a_rd_clear: assert property (p_rd_clear)
        else $error("Read did not clear status.");
    // The intrusion pin reaches the status bit three edges after it is seen high.
    property p_intrusion;
        @(posedge clk) disable iff (rst)
        chassis_intrusion_input ##1 1'b1 |=> ##1 stat_reg[tim_pkg::BIT_CHASS];
    endproperty
    a_intrusion: assert property (p_intrusion)
        else $error("Intrusion not recorded.");
    // Scenarios that the bench is expected to reach.
    c_int: cover property (@(posedge clk) disable iff (rst) $rose(int_out));
    c_hot_once: cover property (@(posedge clk) disable iff (rst)
        mask_reg[tim_pkg::BIT_HOTMD] && hot_set);
    c_rd_set: cover property (@(posedge clk) disable iff (rst) stat_rd && |stat_set);
    c_otl_rearm: cover property (@(posedge clk) disable iff (rst)
        mask_reg[tim_pkg::BIT_OSMD] && otl_set && u_otl.alarm_reg);
    c_masked_pin: cover property (@(posedge clk) disable iff (rst)
        stat_reg[tim_pkg::BIT_CHASS] && mask_reg[tim_pkg::BIT_CHASS] && !int_out);
endmodule // tim_mask_mode
`default_nettype wire

// ---- rtl/tim_pkg.sv ----
// Purpose: Constants for the temperature interrupt mask and mode block.
// Assumes: Register access through a simple documented write/read port.
// Notes:   All offsets, field positions and reset values live here.
package tim_pkg;
    // ==========================================================
    // Register addresses.
    localparam logic [7:0] ADDR_STATUS2 = 8'h02;
    localparam logic [7:0] ADDR_MASK2   = 8'h04;
    // ==========================================================
    // Field positions.
    localparam int BIT_HOT     = 0;
    localparam int BIT_BOARD   = 1;
    localparam int BIT_FAN_ONE = 2;
    localparam int BIT_FAN_TWO = 3;
    localparam int BIT_CHASS   = 4;
    localparam int BIT_OSLIM   = 5;
    localparam int BIT_HOTMD   = 6;
    localparam int BIT_OSMD    = 7;
    // ==========================================================
    // Reset values.
    localparam logic [7:0] MASK2_RESET  = 8'h00;
    localparam logic [7:0] STAT2_RESET  = 8'h00;
    localparam logic [7:0] STAT2_RSVD   = 8'hC0;
    // Mode encodings of the two event channels.
    typedef enum logic {TIM_MODE_DEFAULT, TIM_MODE_ONETIME} tim_mode_t;
    // One-time tracker states.
    typedef enum logic [1:0] {TIM_IDLE, TIM_ABOVE, TIM_BELOW_WAIT} tim_state_t;
endpackage

// ---- rtl/tim_temp_event.sv ----
// Purpose: Per-event limit tracker for one temperature status source.
// Assumes: limit flags are sampled on the conversion-done pulse only.
// Notes:   Produces a one-cycle set request towards the status bit.
`timescale 1ns/1ps
`default_nettype none
module tim_temp_event (
    input  wire logic clk,          // System clock.
    input  wire logic rst,          // Synchronous reset, active high.
    input  wire logic one_time,     // Mode bit: one-time when high.
    input  wire logic conv_done,    // Conversion complete pulse.
    input  wire logic over_limit,   // Temperature above limit.
    input  wire logic below_hyst,   // Temperature below hysteresis.
    output logic      set_pulse     // Request to set the status bit.
);
    // ==========================================================
    // Alarm latch: high from over-limit until temperature falls below hysteresis.
    logic alarm_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_reg <= 1'b0;
        end else if (conv_done) begin
            if (over_limit)
                alarm_reg <= 1'b1;
            else if (below_hyst)
                alarm_reg <= 1'b0;
        end
    end
    // Default mode re-raises every conversion while alarmed; one-time mode
    // raises only on the two edges of the alarm, so a read is not undone.
    always_comb begin
        set_pulse = 1'b0;
        if (conv_done) begin
            if (!one_time) begin
                set_pulse = over_limit || (alarm_reg && !below_hyst);
            end else begin
                set_pulse = (over_limit && !alarm_reg) ||
                            (alarm_reg && !over_limit && below_hyst);
            end
        end
    end
endmodule // tim_temp_event
`default_nettype wire

// ---- tb/tim_mask_mode_tb.sv ----
// Purpose: Self-checking bench for the mask and mode register block.
// Assumes: Inputs change at the falling edge; reads return data one edge later.
// Notes:   Fixed waits after a conversion cover tracker plus status latency.
`timescale 1ns/1ps
`default_nettype none
module tim_mask_mode_tb;
    // ==========================================================
    // Stimulus signals and counters.
    logic       clk, rst, reg_wr, reg_rd, conv_done, fan, chas;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, status_out, mask_out;
    logic [1:0] over, below;
    logic [2:0] low_set;
    logic       int_out;
    int         n_fail, n_compared, cycles;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
    tim_mask_mode dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .conv_done(conv_done), .hot_over(over[0]), .hot_below_hyst(below[0]),
        .otl_over(over[1]), .otl_below_hyst(below[1]), .second_fan_input(fan),
        .chassis_intrusion_input(chas), .low_status_set(low_set),
        .int_out(int_out), .status_out(status_out), .mask_out(mask_out));
    // ==========================================================
    // Clock, and a cycle ceiling so a hang still reaches the verdict.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            results();
        end
    end
    // ==========================================================
    // Access tasks in the block's strobe protocol.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_rd = 1'b1; reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        `CHK(reg_rdata, e)
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // A conversion pulse, then time for tracker and status flop to settle.
    task automatic conv();
        @(negedge clk);
        conv_done = 1'b1;
        @(negedge clk);
        conv_done = 1'b0;
        tick(4);
    endtask
    // Walks both modes of one temperature channel; ch 0 is hot, ch 1 overtemp.
    task automatic temp_seq(input int ch);
        logic [7:0] sb, mb;
        sb = ch ? 8'h20 : 8'h01;
        mb = ch ? 8'h80 : 8'h40;
        wr(tim_pkg::ADDR_MASK2, 8'h00);
        over[ch] = 1'b1; below[ch] = 1'b0;
        conv(); rdchk(tim_pkg::ADDR_STATUS2, sb);
        conv(); rdchk(tim_pkg::ADDR_STATUS2, sb);
        over[ch] = 1'b0;
        conv(); rdchk(tim_pkg::ADDR_STATUS2, sb);
        below[ch] = 1'b1;
        conv(); rdchk(tim_pkg::ADDR_STATUS2, 8'h00);
        wr(tim_pkg::ADDR_MASK2, mb);
        over[ch] = 1'b1; below[ch] = 1'b0;
        conv(); rdchk(tim_pkg::ADDR_STATUS2, sb);
        conv(); rdchk(tim_pkg::ADDR_STATUS2, 8'h00);
        over[ch] = 1'b0;
        conv(); rdchk(tim_pkg::ADDR_STATUS2, 8'h00);
        below[ch] = 1'b1;
        conv(); rdchk(tim_pkg::ADDR_STATUS2, sb);
        conv(); rdchk(tim_pkg::ADDR_STATUS2, 8'h00);
        over[ch] = 1'b1; below[ch] = 1'b0;
        conv(); rdchk(tim_pkg::ADDR_STATUS2, sb);
        // Back to default mode and below hysteresis so the channel goes quiet.
        wr(tim_pkg::ADDR_MASK2, 8'h00);
        over[ch] = 1'b0; below[ch] = 1'b1;
        conv(); rdchk(tim_pkg::ADDR_STATUS2, 8'h00);
    endtask
    // ==========================================================
    // Verdict, reached from the main sequence or the ceiling.
    task automatic results();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // Main sequence.
    initial begin
        n_fail = 0; n_compared = 0; cycles = 0;
        rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
        conv_done = 1'b0; fan = 1'b0; chas = 1'b0; over = 2'b00; below = 2'b11;
        low_set = 3'b000;
        tick(20);
        rst = 1'b0;
        rdchk(tim_pkg::ADDR_MASK2, tim_pkg::MASK2_RESET);
        rdchk(tim_pkg::ADDR_STATUS2, tim_pkg::STAT2_RESET);
        `CHK(int_out, 1'b0)
        wr(tim_pkg::ADDR_MASK2, 8'hA5);
        rdchk(tim_pkg::ADDR_MASK2, 8'hA5);
        `CHK(mask_out, 8'hA5)
        // Status is read-only and an unmapped place reads as zero.
        wr(tim_pkg::ADDR_STATUS2, 8'hFF);
        rdchk(tim_pkg::ADDR_STATUS2, 8'h00);
        rdchk(8'h7E, 8'h00);
        temp_seq(0);
        temp_seq(1);
        // Pin sources with their mask bits set stay off the interrupt.
        wr(tim_pkg::ADDR_MASK2, 8'h38);
        fan = 1'b1; chas = 1'b1;
        tick(5);
        `CHK(int_out, 1'b0)
        `CHK(status_out, 8'h18)
        wr(tim_pkg::ADDR_MASK2, 8'h30); tick(2);
        `CHK(int_out, 1'b1)
        wr(tim_pkg::ADDR_MASK2, 8'h28); tick(2);
        `CHK(int_out, 1'b1)
        wr(tim_pkg::ADDR_MASK2, 8'h18);
        over[1] = 1'b1; below[1] = 1'b0;
        conv();
        `CHK(int_out, 1'b1)
        wr(tim_pkg::ADDR_MASK2, 8'h38); tick(2);
        `CHK(int_out, 1'b0)
        fan = 1'b0; chas = 1'b0; over[1] = 1'b0; below[1] = 1'b1;
        tick(5);
        rdchk(tim_pkg::ADDR_STATUS2, 8'h38);
        rdchk(tim_pkg::ADDR_STATUS2, 8'h00);
        // A lower status source drives the interrupt until read.
        wr(tim_pkg::ADDR_MASK2, 8'h00);
        @(negedge clk);
        low_set = 3'b010;
        @(negedge clk);
        low_set = 3'b000;
        tick(2);
        `CHK(int_out, 1'b1)
        rdchk(tim_pkg::ADDR_STATUS2, 8'h02);
        tick(2);
        `CHK(int_out, 1'b0)
        results();
    end
endmodule // tim_mask_mode_tb
`default_nettype wire
